// File: common/usb_ctrl_pkg.sv
/*
  Package for the USB general and device control block: constants, states and carriers.
  Assumes a single 20 MHz clock and synchronous active-low reset.
*/
package usb_ctrl_pkg;
  localparam int unsigned NUM_EP = 8;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;
  localparam logic [1:0] SPD_RST = 2'h0;
  localparam logic [7:0] EP_CFG_RST = 8'h00;
  localparam logic [7:0] EP_CTL_RST = 8'h00;
  localparam logic [1:0] EP_TYPE_ISO = 2'h1;
  localparam logic [1:0] EP_TYPE_BULK = 2'h2;
  localparam logic [1:0] EP_TYPE_INT = 2'h3;
  localparam logic [1:0] SPEED_FULL = 2'h0;
  localparam logic [1:0] SPEED_LOW = 2'h1;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BUS_RST_NS = 2_500;
  localparam int unsigned BUS_RST_CYC = (BUS_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_DEVICE_IDLE,
    ST_HOST_IDLE
  } ctrl_state_t;

  typedef struct packed {
    logic controller_enable;
    logic freeze_clock_bit;
    logic role_select;
    logic low_speed_select;
  } general_ctrl_t;

  typedef struct packed {
    logic dp_pullup;
    logic dm_pullup;
    logic dp_pulldown;
    logic dm_pulldown;
    logic pad_active;
  } pad_ctrl_t;
endpackage

// File: src/usb_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module usb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: src/usb_general_and_device_control.sv
/*
  General control, pad control and device-mode reset handling of a USB controller,
  with a FIFO in the received data path. Assumes inputs synchronous to clk_i; bus
  events (suspend, non-idle, bus reset, id change) arrive as one-cycle pulses.
*/
// Functional notes
// - Reset leaves the controller disabled, frozen, pad idle, internal state cleared.
// - Freeze, enable, role and speed bits are writable in reset, applied once unfrozen.
// - Enable moves to idle in device or host mode per role select.
// - Clearing enable acts as reset but keeps freeze, role and speed bits.
// - While frozen only role, freeze, enable and speed bits and the flag clears accept writes.
// - While frozen only asynchronous sources raise the interrupt.
// - Id change, wakeup and host wakeup interrupts work without the clock.
// - All interrupt causes combine onto one request line.
// - Device pull-up goes on D+ for full speed, D- for low speed.
// - Host mode pulls down both lines and reports detected speed.
// - Suspend sets its flag and idles the pad; activity sets wakeup, activates pad.
// - Pad idles on disable or detach; activates on enable with detach clear.
// - Device mode has eight endpoints, each iso, bulk or interrupt.
// - After reset endpoints are disabled, no pull-up, detach reads one.
// - Clearing detach applies the pull-up matching the selected speed.
// - Device mode resets on disable or when id selects host.
// - Bus reset clears device control but detach and speed config: frame, endpoints, toggles.
// - End of bus reset handling sets the bus reset done flag.
// - Bus reset also clears device address and its valid bit.
`timescale 1ns/1ps
module usb_general_and_device_control
  import usb_ctrl_pkg::*;
#(
  parameter int unsigned N_EP = NUM_EP
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire usb_ctrl_pkg::general_ctrl_t gen_wr_data_i,
  input wire logic gen_wr_i,
  input wire logic detach_wr_data_i,
  input wire logic detach_wr_i,
  input wire logic [6:0] addr_wr_data_i,
  input wire logic addr_wr_i,
  input wire logic addr_valid_wr_data_i,
  input wire logic addr_valid_wr_i,
  input wire logic [1:0] speed_cfg_wr_data_i,
  input wire logic speed_cfg_wr_i,
  input wire logic [2:0] ep_sel_i,
  input wire logic [7:0] ep_cfg_wr_data_i,
  input wire logic ep_cfg_wr_i,
  input wire logic [7:0] ep_ctl_wr_data_i,
  input wire logic ep_ctl_wr_i,
  input wire logic ep_toggle_flip_i,
  input wire logic sof_i,
  input wire logic [10:0] frame_num_i,
  input wire logic id_i,
  input wire logic id_change_i,
  input wire logic host_resume_i,
  input wire logic bus_suspend_i,
  input wire logic bus_non_idle_i,
  input wire logic bus_reset_i,
  input wire logic [1:0] host_speed_detect_i,
  input wire logic [2:0] irq_clear_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] fifo_data_o,
  output logic fifo_valid_o,
  input wire logic fifo_ready_i,
  output usb_ctrl_pkg::general_ctrl_t gen_status_o,
  output usb_ctrl_pkg::ctrl_state_t state_o,
  output usb_ctrl_pkg::pad_ctrl_t pad_o,
  output logic detach_o,
  output logic [6:0] addr_o,
  output logic addr_valid_o,
  output logic [1:0] speed_cfg_o,
  output logic [1:0] speed_status_o,
  output logic [10:0] frame_num_o,
  output logic [7:0] ep_cfg_o,
  output logic [7:0] ep_ctl_o,
  output logic [N_EP-1:0] ep_toggle_o,
  output logic bus_idle_flag_o,
  output logic wakeup_flag_o,
  output logic bus_reset_done_flag_o,
  output logic id_change_irq_o,
  output logic host_resume_irq_o,
  output logic irq_o
);
  import usb_ctrl_pkg::*;

  general_ctrl_t gen_q;
  ctrl_state_t state_q;
  logic running;
  logic dev_run;
  logic dev_clr;
  logic detach_q;
  logic pad_active_q;
  logic [6:0] addr_q;
  logic addr_valid_q;
  logic [1:0] spd_q;
  logic [1:0] spd_stat_q;
  logic [10:0] frame_q;
  logic [7:0] ep_cfg_q [N_EP];
  logic [7:0] ep_ctl_q [N_EP];
  logic [N_EP-1:0] tog_q;
  logic rst_busy_q;
  logic [7:0] rst_cnt_q;
  logic bus_idle_flag_q;
  logic wake_q;
  logic bus_reset_done_flag_q;
  logic id_change_irq_q;
  logic hwup_q;
  logic fifo_in_ready;

  // Settings count only once the controller is both enabled and unfrozen.
  assign running = gen_q.controller_enable && !gen_q.freeze_clock_bit;
  assign dev_run = running && (state_q == ST_DEVICE_IDLE) && id_i;
  assign dev_clr = !gen_q.controller_enable || !id_i;

  // These bits stay writable while frozen; a disable keeps them.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      gen_q <= '{controller_enable: 1'b0, freeze_clock_bit: 1'b1,
                 role_select: 1'b0, low_speed_select: 1'b0};
    end
    else if (gen_wr_i)
    begin
      gen_q <= gen_wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ST_RESET;
    end
    else
    begin
      case (state_q)
        ST_RESET:
        begin
          // A frozen enable waits here, so role and speed are only applied unfrozen.
          if (running)
          begin
            state_q <= gen_q.role_select ? ST_DEVICE_IDLE : ST_HOST_IDLE;
          end
        end
        ST_DEVICE_IDLE, ST_HOST_IDLE:
        begin
          if (!gen_q.controller_enable)
          begin
            state_q <= ST_RESET;
          end
        end
        default:
        begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // Detach is ignored while frozen, so it always has a defined value at unfreeze.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !gen_q.controller_enable)
    begin
      detach_q <= 1'b1;
    end
    else if (detach_wr_i && !gen_q.freeze_clock_bit)
    begin
      detach_q <= detach_wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !gen_q.controller_enable)
    begin
      pad_active_q <= 1'b0;
    end
    else if (detach_wr_i && detach_wr_data_i)
    begin
      pad_active_q <= 1'b0;
    end
    else if (bus_non_idle_i && running)
    begin
      pad_active_q <= 1'b1;
    end
    else if (bus_suspend_i && running)
    begin
      pad_active_q <= 1'b0;
    end
    else if (detach_wr_i && !detach_wr_data_i && !gen_q.freeze_clock_bit)
    begin
      pad_active_q <= 1'b1;
    end
  end

  // Pull-up follows the speed bit only while attached in device mode.
  always_comb
  begin
    pad_o = '0;
    pad_o.pad_active = pad_active_q;
    if (state_q == ST_DEVICE_IDLE && !detach_q)
    begin
      pad_o.dp_pullup = !gen_q.low_speed_select;
      pad_o.dm_pullup = gen_q.low_speed_select;
    end
    else if (state_q == ST_HOST_IDLE)
    begin
      pad_o.dp_pulldown = 1'b1;
      pad_o.dm_pulldown = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !gen_q.controller_enable)
    begin
      spd_stat_q <= SPEED_FULL;
    end
    else if (running && state_q == ST_HOST_IDLE)
    begin
      spd_stat_q <= host_speed_detect_i;
    end
  end

  // Bus reset window: a fixed hold after the request before completion is flagged.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || dev_clr)
    begin
      rst_busy_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (bus_reset_i && dev_run)
    begin
      rst_busy_q <= 1'b1;
      rst_cnt_q <= 8'(BUS_RST_CYC - 1);
    end
    else if (rst_busy_q)
    begin
      if (rst_cnt_q == '0)
      begin
        rst_busy_q <= 1'b0;
      end
      else
      begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || dev_clr || rst_busy_q)
    begin
      addr_q <= ADDR_RST;
      addr_valid_q <= 1'b0;
    end
    else if (dev_run)
    begin
      if (addr_wr_i)
      begin
        addr_q <= addr_wr_data_i;
      end
      if (addr_valid_wr_i)
      begin
        addr_valid_q <= addr_valid_wr_data_i;
      end
    end
  end

  // Speed config survives a bus reset but not a disable.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || dev_clr)
    begin
      spd_q <= SPD_RST;
    end
    else if (speed_cfg_wr_i && dev_run)
    begin
      spd_q <= speed_cfg_wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || dev_clr || rst_busy_q)
    begin
      frame_q <= FRAME_RST;
      tog_q <= '0;
    end
    else if (dev_run)
    begin
      if (sof_i)
      begin
        frame_q <= frame_num_i;
      end
      if (ep_toggle_flip_i)
      begin
        tog_q[ep_sel_i] <= !tog_q[ep_sel_i];
      end
    end
  end

  // Endpoint type sits in bits 1:0 of each config entry.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < int'(N_EP); i++)
    begin
      if (!rstn_i || dev_clr || rst_busy_q)
      begin
        ep_cfg_q[i] <= EP_CFG_RST;
        ep_ctl_q[i] <= EP_CTL_RST;
      end
      else if (dev_run && ep_sel_i == 3'(i))
      begin
        if (ep_cfg_wr_i)
        begin
          ep_cfg_q[i] <= ep_cfg_wr_data_i;
        end
        if (ep_ctl_wr_i)
        begin
          ep_ctl_q[i] <= ep_ctl_wr_data_i;
        end
      end
    end
  end

  // Flags: set wins over a same-cycle clear. Clear index 0 suspend/wakeup/reset-done,
  // 1 id change, 2 host resume.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || dev_clr)
    begin
      bus_idle_flag_q <= 1'b0;
      wake_q <= 1'b0;
      bus_reset_done_flag_q <= 1'b0;
    end
    else
    begin
      if (bus_suspend_i && dev_run)
      begin
        bus_idle_flag_q <= 1'b1;
      end
      else if (irq_clear_i[0] || (bus_non_idle_i && dev_run))
      begin
        bus_idle_flag_q <= 1'b0;
      end
      // Wakeup is an asynchronous source and is seen even while frozen.
      if (bus_non_idle_i && gen_q.controller_enable && state_q == ST_DEVICE_IDLE)
      begin
        wake_q <= 1'b1;
      end
      else if (irq_clear_i[0])
      begin
        wake_q <= 1'b0;
      end
      if (rst_busy_q && rst_cnt_q == '0)
      begin
        bus_reset_done_flag_q <= 1'b1;
      end
      else if (irq_clear_i[0])
      begin
        bus_reset_done_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !gen_q.controller_enable)
    begin
      id_change_irq_q <= 1'b0;
      hwup_q <= 1'b0;
    end
    else
    begin
      if (id_change_i)
      begin
        id_change_irq_q <= 1'b1;
      end
      else if (irq_clear_i[1])
      begin
        id_change_irq_q <= 1'b0;
      end
      if (host_resume_i && state_q == ST_HOST_IDLE)
      begin
        hwup_q <= 1'b1;
      end
      else if (irq_clear_i[2])
      begin
        hwup_q <= 1'b0;
      end
    end
  end

  // Clocked causes are masked by freeze; only the asynchronous ones pass.
  assign irq_o = id_change_irq_q || hwup_q || wake_q
                 || (!gen_q.freeze_clock_bit && (bus_idle_flag_q || bus_reset_done_flag_q));

  // Received data is held back while the device is not running.
  assign rx_ready_o = fifo_in_ready && dev_run;

  usb_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .flush_i(dev_clr),
    .in_data_i(rx_data_i),
    .in_valid_i(rx_valid_i && dev_run),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data_o),
    .out_valid_o(fifo_valid_o),
    .out_ready_i(fifo_ready_i)
  );

  assign gen_status_o = gen_q;
  assign state_o = state_q;
  assign detach_o = detach_q;
  assign addr_o = addr_q;
  assign addr_valid_o = addr_valid_q;
  assign speed_cfg_o = spd_q;
  assign speed_status_o = spd_stat_q;
  assign frame_num_o = frame_q;
  assign ep_cfg_o = ep_cfg_q[ep_sel_i];
  assign ep_ctl_o = ep_ctl_q[ep_sel_i];
  assign ep_toggle_o = tog_q;
  assign bus_idle_flag_o = bus_idle_flag_q;
  assign wakeup_flag_o = wake_q;
  assign bus_reset_done_flag_o = bus_reset_done_flag_q;
  assign id_change_irq_o = id_change_irq_q;
  assign host_resume_irq_o = hwup_q;

  chk_reset_defaults: assert property (@(posedge clk_i)
    !rstn_i |=> (state_q == ST_RESET && gen_q.freeze_clock_bit && !pad_active_q && detach_q))
    else $error("reset defaults wrong");
  chk_enable_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_RESET && running && !gen_wr_i |=>
    state_q == (gen_q.role_select ? ST_DEVICE_IDLE : ST_HOST_IDLE))
    else $error("enable did not enter idle");
  chk_disable_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !gen_q.controller_enable && !gen_wr_i |=> $stable(gen_q) && detach_q && !addr_valid_q)
    else $error("disable reset wrong");
  chk_freeze_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen_q.freeze_clock_bit && !id_change_irq_q && !hwup_q && !wake_q |-> !irq_o)
    else $error("irq while frozen");
  chk_pullup_speed: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_DEVICE_IDLE && !detach_q |->
    pad_o.dm_pullup == gen_q.low_speed_select && pad_o.dp_pullup != gen_q.low_speed_select)
    else $error("pull-up wrong");
  chk_host_pulldown: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_HOST_IDLE |-> pad_o.dp_pulldown && pad_o.dm_pulldown && !pad_o.dp_pullup)
    else $error("host pull-down missing");
  chk_suspend_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_suspend_i && dev_run && !bus_non_idle_i && !detach_wr_i && gen_q.controller_enable
    |=> bus_idle_flag_q && !pad_active_q)
    else $error("suspend not handled");
  sequence s_bus_reset;
    bus_reset_i && dev_run && !dev_clr;
  endsequence
  sequence s_reset_done;
    ##[1:200] bus_reset_done_flag_q;
  endsequence
  chk_bus_reset_clear: assert property (@(posedge clk_i) disable iff (!rstn_i || dev_clr)
    s_bus_reset |=> ##1 frame_q == FRAME_RST && tog_q == '0 && !addr_valid_q)
    else $error("bus reset did not clear");
  chk_reset_done: assert property (@(posedge clk_i) disable iff (!rstn_i || dev_clr)
    s_bus_reset |-> s_reset_done)
    else $error("bus reset done not flagged");
  chk_dev_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !id_i |=> !rst_busy_q && frame_q == FRAME_RST)
    else $error("host id did not reset device");
endmodule

// File: tb/usb_host_model.sv
/*
  Behavioural model of the far end of the USB cable: raises bus events as one-cycle
  pulses and hands received bytes to the block over a valid/ready handshake.
  Assumes the testbench calls its tasks just after a rising edge of clk_i.
*/
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic [4:0] event_o
);
  initial
  begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'h0;
    event_o = 5'h00;
  end

  // Event order on event_o: suspend, activity, bus reset, id change, host resume.
  task automatic pulse(input int k);
    @(posedge clk_i);
    event_o <= 5'h01 << k;
    @(posedge clk_i);
    event_o <= 5'h00;
  endtask

  // A released data line shows the inverse of its last byte, so stale data never matches.
  task automatic idle();
    rx_valid_o <= 1'h0;
    rx_data_o <= ~rx_data_o;
  endtask

  // Holds the byte until ready is seen high at an edge; gives up after 64 edges.
  task automatic send(input logic [7:0] b, input int gap, output bit ok);
    int n;
    n = 0;
    if (gap > 0)
    begin
      idle();
      repeat (gap) @(posedge clk_i);
    end
    rx_data_o <= b;
    rx_valid_o <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rx_ready_i !== 1'h1 && n < 64);
    ok = (n < 64);
  endtask
endmodule

// File: tb/usb_general_and_device_control_test.sv
/*
  Self-checking testbench of the USB general and device control block.
  Assumes the host model in its own file and the block's package; one 20 MHz clock.
*/
`timescale 1ns/1ps
module usb_general_and_device_control_test
  import usb_ctrl_pkg::*;
;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [10:0] wd;
  logic [9:0] stb;
  logic [2:0] sel;
  logic id;
  logic [1:0] hs;
  logic fifo_rdy;
  logic [7:0] rxd;
  logic rxv;
  logic [4:0] ev;
  logic rx_ready_o, fifo_valid_o, detach_o, addr_valid_o, bus_idle_flag_o, wakeup_flag_o;
  logic bus_reset_done_flag_o, id_change_irq_o, host_resume_irq_o, irq_o;
  logic [7:0] fifo_data_o, ep_cfg_o, ep_ctl_o, ep_toggle_o;
  logic [6:0] addr_o;
  logic [1:0] speed_cfg_o, speed_status_o;
  logic [10:0] frame_num_o;
  general_ctrl_t gen_status_o;
  ctrl_state_t state_o;
  pad_ctrl_t pad_o;
  int seed = 32'h0510_1202;
  int failures = 0;
  int total_checks = 0;

  always #25 clk_i = ~clk_i;

  usb_host_model host (.clk_i(clk_i), .rx_ready_i(rx_ready_o), .rx_data_o(rxd),
    .rx_valid_o(rxv), .event_o(ev));

  usb_general_and_device_control dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .gen_wr_data_i(general_ctrl_t'(wd[3:0])),
    .gen_wr_i(stb[0]), .detach_wr_data_i(wd[0]), .detach_wr_i(stb[1]),
    .addr_wr_data_i(wd[6:0]), .addr_wr_i(stb[2]), .addr_valid_wr_data_i(wd[0]),
    .addr_valid_wr_i(stb[3]), .speed_cfg_wr_data_i(wd[1:0]), .speed_cfg_wr_i(stb[4]),
    .ep_sel_i(sel), .ep_cfg_wr_data_i(wd[7:0]), .ep_cfg_wr_i(stb[5]),
    .ep_ctl_wr_data_i(wd[7:0]), .ep_ctl_wr_i(stb[6]), .ep_toggle_flip_i(stb[7]),
    .sof_i(stb[8]), .frame_num_i(wd), .id_i(id), .id_change_i(ev[3]),
    .host_resume_i(ev[4]), .bus_suspend_i(ev[0]), .bus_non_idle_i(ev[1]),
    .bus_reset_i(ev[2]), .host_speed_detect_i(hs), .irq_clear_i(wd[2:0] & {3{stb[9]}}),
    .rx_data_i(rxd), .rx_valid_i(rxv), .rx_ready_o(rx_ready_o), .fifo_data_o(fifo_data_o),
    .fifo_valid_o(fifo_valid_o), .fifo_ready_i(fifo_rdy), .gen_status_o(gen_status_o),
    .state_o(state_o), .pad_o(pad_o), .detach_o(detach_o), .addr_o(addr_o),
    .addr_valid_o(addr_valid_o), .speed_cfg_o(speed_cfg_o), .speed_status_o(speed_status_o),
    .frame_num_o(frame_num_o), .ep_cfg_o(ep_cfg_o), .ep_ctl_o(ep_ctl_o),
    .ep_toggle_o(ep_toggle_o), .bus_idle_flag_o(bus_idle_flag_o),
    .wakeup_flag_o(wakeup_flag_o), .bus_reset_done_flag_o(bus_reset_done_flag_o),
    .id_change_irq_o(id_change_irq_o), .host_resume_irq_o(host_resume_irq_o), .irq_o(irq_o));

  function automatic logic [1:0] exp_pull(input logic ls);
    return {~ls, ls};
  endfunction

  function automatic logic [1:0] ep_type(input int i);
    return (i % 3 == 0) ? EP_TYPE_ISO : (i % 3 == 1) ? EP_TYPE_BULK : EP_TYPE_INT;
  endfunction

  task automatic close_out();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  // Strobe k: 0 general, 1 detach, 2 address, 3 address valid, 4 speed, 5 ep config,
  // 6 ep control, 7 toggle flip, 8 frame, 9 flag clear.
  task automatic wr(input int k, input logic [10:0] v);
    @(posedge clk_i);
    wd <= v;
    stb <= 10'h001 << k;
    @(posedge clk_i);
    stb <= 10'h000;
  endtask

  task automatic after(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
  end

  initial
  begin
    logic [7:0] b;
    logic [7:0] cfg [8];
    logic [7:0] ctl [8];
    logic [7:0] q [$];
    logic [6:0] a;
    logic [1:0] sp;
    logic [10:0] fr;
    bit ok;
    int cnt;
    wd <= 11'h000;
    stb <= 10'h000;
    sel <= 3'h0;
    id <= 1'h1;
    hs <= 2'h0;
    fifo_rdy <= 1'h0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'h1;
    after(0);
    chk_val(gen_status_o, 16'h0004);
    chk_val(state_o, ST_RESET);
    chk_val({detach_o, pad_o.dp_pullup, pad_o.dm_pullup, pad_o.pad_active}, 16'h0008);
    chk_val({ep_toggle_o, frame_num_o == 11'h000, irq_o, bus_idle_flag_o}, 16'h0004);
    wr(0, 11'h00e);
    after(2);
    chk_val(gen_status_o, 16'h000e);
    chk_val(state_o, ST_RESET);
    wr(1, 11'h000);
    after(0);
    chk_bit(detach_o, 1'h1);
    host.pulse(4);
    host.pulse(3);
    after(0);
    chk_val({host_resume_irq_o, id_change_irq_o, irq_o}, 16'h0003);
    wr(9, 11'h006);
    host.pulse(0);
    after(0);
    chk_bit(irq_o, 1'h0);
    for (int ls = 0; ls < 2; ls++)
    begin
      wr(0, {7'h00, 3'h5, ls[0]});
      after(2);
      chk_val(state_o, ST_DEVICE_IDLE);
      wr(1, 11'h000);
      after(0);
      chk_val({pad_o.dp_pullup, pad_o.dm_pullup}, exp_pull(ls[0]));
      chk_bit(pad_o.pad_active, 1'h1);
      wr(1, 11'h001);
      after(0);
      chk_val({pad_o.pad_active, pad_o.dp_pullup, pad_o.dm_pullup}, 16'h0000);
      wr(1, 11'h000);
      wr(0, {7'h00, 3'h1, ls[0]});
      after(2);
      chk_val({gen_status_o, state_o}, {3'h1, ls[0], ST_RESET});
      chk_val({detach_o, pad_o.pad_active}, 16'h0002);
    end
    hs <= 2'($random(seed));
    wr(0, 11'h008);
    after(2);
    chk_val(state_o, ST_HOST_IDLE);
    chk_val({pad_o.dp_pulldown, pad_o.dm_pulldown, speed_status_o}, {2'h3, hs});
    host.pulse(4);
    after(0);
    chk_val({host_resume_irq_o, irq_o}, 16'h0003);
    wr(0, 11'h000);
    wr(0, 11'h00a);
    after(2);
    wr(1, 11'h000);
    a = 7'($random(seed));
    sp = 2'($random(seed));
    fr = 11'($random(seed));
    wr(2, {4'h0, a});
    wr(3, 11'h001);
    wr(4, {9'h000, sp});
    wr(8, fr);
    for (int i = 0; i < NUM_EP; i++)
    begin
      sel <= i[2:0];
      cfg[i] = {6'($random(seed)), ep_type(i)};
      ctl[i] = 8'($random(seed));
      wr(5, {3'h0, cfg[i]});
      wr(6, {3'h0, ctl[i]});
      wr(7, 11'h000);
    end
    for (int i = 0; i < NUM_EP; i++)
    begin
      sel <= i[2:0];
      after(0);
      chk_val({ep_cfg_o, ep_ctl_o}, {cfg[i], ctl[i]});
    end
    chk_val({addr_valid_o, addr_o, ep_toggle_o}, {1'h1, a, 8'hff});
    chk_val(frame_num_o, fr);
    wr(0, 11'h00e);
    wr(2, {4'h0, ~a});
    after(0);
    chk_val(addr_o, a);
    wr(0, 11'h00a);
    after(2);
    host.pulse(2);
    cnt = 0;
    while (bus_reset_done_flag_o !== 1'h1 && cnt < 200)
    begin
      @(negedge clk_i);
      cnt++;
    end
    chk_bit(cnt >= BUS_RST_CYC && cnt <= BUS_RST_CYC + 2, 1'h1);
    chk_bit(irq_o, 1'h1);
    chk_val({frame_num_o, ep_toggle_o == 8'h00}, 16'h0001);
    chk_val({addr_o, addr_valid_o}, 16'h0000);
    chk_val({detach_o, speed_cfg_o}, {1'h0, sp});
    for (int i = 0; i < NUM_EP; i++)
    begin
      sel <= i[2:0];
      after(0);
      chk_val({ep_cfg_o, ep_ctl_o}, 16'h0000);
    end
    wr(9, 11'h001);
    host.pulse(0);
    after(0);
    chk_val({bus_idle_flag_o, pad_o.pad_active, irq_o}, 16'h0005);
    host.pulse(1);
    after(0);
    chk_val({wakeup_flag_o, pad_o.pad_active}, 16'h0003);
    wr(9, 11'h001);
    after(0);
    chk_bit(irq_o, 1'h0);
    @(posedge clk_i);
    for (int i = 0; i < FIFO_D; i++)
    begin
      b = 8'($random(seed));
      host.send(b, i % 3, ok);
      q.push_back(b);
      chk_bit(ok, 1'h1);
    end
    host.send(8'($random(seed)), 0, ok);
    host.idle();
    chk_bit(ok, 1'h0);
    after(0);
    chk_bit(rx_ready_o, 1'h0);
    cnt = 0;
    while (q.size() > 0 && cnt < 200)
    begin
      @(posedge clk_i);
      if (fifo_valid_o === 1'h1 && fifo_rdy === 1'h1)
      begin
        chk_val(fifo_data_o, q.pop_front());
      end
      fifo_rdy <= 1'($random(seed));
      cnt++;
    end
    chk_bit(q.size() == 0, 1'h1);
    after(1);
    chk_bit(fifo_valid_o, 1'h0);
    wr(2, {4'h0, a});
    host.send(8'h5a, 0, ok);
    host.idle();
    fifo_rdy <= 1'h0;
    id <= 1'h0;
    after(2);
    chk_val({fifo_valid_o, rx_ready_o, addr_o}, 16'h0000);
    id <= 1'h1;
    wr(0, 11'h000);
    after(2);
    close_out();
  end
endmodule
